// ==== amdc_pkg.sv ====
// Purpose: Shared constants and types for the main digital control bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Zone and gain value registers sit in the bank as control sources
`default_nettype none
package amdc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ZONE_VAL_OFS   = 8'h42;
  localparam logic [7:0] GAIN_VAL_OFS   = 8'h44;
  localparam logic [7:0] NYQ_CTRL_OFS   = 8'h4E;
  localparam logic [7:0] GAIN_REORD_OFS = 8'h52;
  localparam logic [7:0] REORD2_OFS     = 8'h72;
  localparam logic [7:0] LSB_EN_OFS     = 8'hAB;
  localparam logic [7:0] LSB_SRC_OFS    = 8'hAD;
  localparam logic [7:0] DIG_RST_OFS    = 8'hF7;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NYQ_EN_BIT    = 7;
  localparam int GAIN_EN_BIT   = 0;
  localparam int REORD1_BIT    = 7;
  localparam int REORD2_BIT    = 3;
  localparam int LSB_EN_BIT    = 0;
  localparam int DIG_RST_BIT   = 0;
  localparam int ZONE_W        = 3;
  localparam int GAIN_W        = 7;
  localparam int LSB_SRC_W     = 2;
  localparam int ADC_W         = 12;
  localparam int OUT_W         = 16;
  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [1:0] LSB_SRC_DATA  = 2'h0;
  localparam logic [1:0] LSB_SRC_FAST_OVERRANGE_FLAG  = 2'h3;
  localparam logic [2:0] ZONE_FIRST    = 3'h0;
  localparam logic [2:0] ZONE_SECOND   = 3'h1;
  localparam logic [2:0] ZONE_THIRD    = 3'h2;
  localparam logic [6:0] GAIN_UNITY    = 7'h20;

  typedef struct packed {
    logic       zone_en;
    logic [2:0] zone;
    logic       zone_valid;
    logic       gain_en;
    logic [6:0] gain;
    logic       reorder_enable_first;
    logic       reorder_enable_second;
  } amdc_ctrl_t;
endpackage
`default_nettype wire

// ==== amdc_top.sv ====
// Purpose: Main digital control register bank with output word shaping
// Assumes: One 100 MHz clock; sample inputs are synchronous to it
// Notes:   Digital reset pulse spares the interleaving correction state
`default_nettype none
module amdc_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Register port
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output var  logic [7:0]           rdata_o,
  // Converter samples, two channels
  input  wire logic [11:0]          adc_a_i,
  input  wire logic [11:0]          adc_b_i,
  input  wire logic                 fast_overrange_flag_a_i,
  input  wire logic                 fast_overrange_flag_b_i,
  // Datapath outputs
  output var  logic [15:0]          out_a_o,
  output var  logic [15:0]          out_b_o,
  output var  amdc_pkg::amdc_ctrl_t ctrl_o,
  output var  logic                 digital_block_reset_o
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [2:0] zone_r, zone_nxt;
  logic       nyq_en_r, nyq_en_nxt;
  logic [6:0] gain_r, gain_nxt;
  logic       gain_en_r, gain_en_nxt;
  logic       reord1_r, reord1_nxt;
  logic       reord2_r, reord2_nxt;
  logic       lsb_en_r, lsb_en_nxt;
  logic [1:0] lsb_src_r, lsb_src_nxt;
  logic       drst_r, drst_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    zone_nxt    = zone_r;
    nyq_en_nxt  = nyq_en_r;
    gain_nxt    = gain_r;
    gain_en_nxt = gain_en_r;
    reord1_nxt  = reord1_r;
    reord2_nxt  = reord2_r;
    lsb_en_nxt  = lsb_en_r;
    lsb_src_nxt = lsb_src_r;
    drst_nxt    = 1'b0;
    rdata_nxt   = 8'h00;
    // Reserved bits ignored on write, relying on host writing zero
    if (wr_i) begin
      case (addr_i)
        amdc_pkg::ZONE_VAL_OFS:   zone_nxt    = wdata_i[amdc_pkg::ZONE_W-1:0];
        amdc_pkg::GAIN_VAL_OFS:   gain_nxt    = wdata_i[amdc_pkg::GAIN_W-1:0];
        amdc_pkg::NYQ_CTRL_OFS:   nyq_en_nxt  = wdata_i[amdc_pkg::NYQ_EN_BIT];
        amdc_pkg::GAIN_REORD_OFS: begin
          gain_en_nxt = wdata_i[amdc_pkg::GAIN_EN_BIT];
          reord1_nxt  = wdata_i[amdc_pkg::REORD1_BIT];
        end
        amdc_pkg::REORD2_OFS:     reord2_nxt  = wdata_i[amdc_pkg::REORD2_BIT];
        amdc_pkg::LSB_EN_OFS:     lsb_en_nxt  = wdata_i[amdc_pkg::LSB_EN_BIT];
        amdc_pkg::LSB_SRC_OFS:    lsb_src_nxt = wdata_i[amdc_pkg::LSB_SRC_W-1:0];
        amdc_pkg::DIG_RST_OFS:    drst_nxt    = wdata_i[amdc_pkg::DIG_RST_BIT];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        amdc_pkg::ZONE_VAL_OFS:   rdata_nxt = {5'h00, zone_r};
        amdc_pkg::GAIN_VAL_OFS:   rdata_nxt = {1'b0, gain_r};
        amdc_pkg::NYQ_CTRL_OFS:   rdata_nxt = {nyq_en_r, 7'h00};
        amdc_pkg::GAIN_REORD_OFS: rdata_nxt = {reord1_r, 6'h00, gain_en_r};
        amdc_pkg::REORD2_OFS:     rdata_nxt = {4'h0, reord2_r, 3'h0};
        amdc_pkg::LSB_EN_OFS:     rdata_nxt = {7'h00, lsb_en_r};
        amdc_pkg::LSB_SRC_OFS:    rdata_nxt = {6'h00, lsb_src_r};
        default:                  rdata_nxt = 8'h00;
      endcase
    end
  end

  // Bank lives on the chip reset only; the digital pulse never touches it
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      zone_r    <= amdc_pkg::REG_RST[2:0];
      nyq_en_r  <= 1'b0;
      gain_r    <= amdc_pkg::REG_RST[6:0];
      gain_en_r <= 1'b0;
      reord1_r  <= 1'b0;
      reord2_r  <= 1'b0;
      lsb_en_r  <= 1'b0;
      lsb_src_r <= amdc_pkg::REG_RST[1:0];
      drst_r    <= 1'b0;
      rdata_r   <= amdc_pkg::REG_RST;
    end else begin
      zone_r    <= zone_nxt;
      nyq_en_r  <= nyq_en_nxt;
      gain_r    <= gain_nxt;
      gain_en_r <= gain_en_nxt;
      reord1_r  <= reord1_nxt;
      reord2_r  <= reord2_nxt;
      lsb_en_r  <= lsb_en_nxt;
      lsb_src_r <= lsb_src_nxt;
      drst_r    <= drst_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Datapath shaping
  // ----------------------------------------
  function automatic logic [15:0] shape(input logic [11:0] s, input logic f, input logic en,
                                        input logic [1:0] src);
    logic [15:0] w;
    w = {s, 4'h0};
    if (en && src == amdc_pkg::LSB_SRC_FAST_OVERRANGE_FLAG) begin
      w[0] = f;
    end
    return w;
  endfunction

  amdc_pkg::amdc_ctrl_t ctrl_r, ctrl_nxt;
  logic [15:0] out_a_r, out_a_nxt, out_b_r, out_b_nxt;

  always_comb begin
    out_a_nxt = shape(adc_a_i, fast_overrange_flag_a_i, lsb_en_r, lsb_src_r);
    out_b_nxt = shape(adc_b_i, fast_overrange_flag_b_i, lsb_en_r, lsb_src_r);
    // Disabled gain presents unity code so the datapath sees a clean bypass
    ctrl_nxt.zone_en    = nyq_en_r;
    ctrl_nxt.zone       = nyq_en_r ? zone_r : amdc_pkg::ZONE_FIRST;
    ctrl_nxt.zone_valid = (zone_r == amdc_pkg::ZONE_FIRST) || (zone_r == amdc_pkg::ZONE_SECOND)
                          || (zone_r == amdc_pkg::ZONE_THIRD);
    ctrl_nxt.gain_en    = gain_en_r;
    ctrl_nxt.gain       = gain_en_r ? gain_r : amdc_pkg::GAIN_UNITY;
    ctrl_nxt.reorder_enable_first  = reord1_r;
    ctrl_nxt.reorder_enable_second = reord2_r;
  end

  // Sample words clear under digital reset; the whole control word is kept out of it
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_a_r <= 16'h0000;
      out_b_r <= 16'h0000;
      ctrl_r  <= '0;
    end else begin
      out_a_r <= drst_r ? 16'h0000 : out_a_nxt;
      out_b_r <= drst_r ? 16'h0000 : out_b_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  assign rdata_o               = rdata_r;
  assign out_a_o               = out_a_r;
  assign out_b_o               = out_b_r;
  assign ctrl_o                = ctrl_r;
  assign digital_block_reset_o = drst_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rst_wr;
    wr_i && addr_i == amdc_pkg::DIG_RST_OFS && wdata_i[0];
  endsequence
  property p_rst_pulse;
    @(posedge clk_i) disable iff (!rst_n_r) s_rst_wr |=> drst_r ##1 !drst_r || $past(wr_i);
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("digital reset not a pulse");
  property p_zone_gate;
    @(posedge clk_i) disable iff (!rst_n_r) !nyq_en_r |=> ctrl_r.zone == 3'h0;
  endproperty
  a_zone_gate: assert property (p_zone_gate) else $error("zone passed while disabled");
  property p_gain_gate;
    @(posedge clk_i) disable iff (!rst_n_r) gain_en_r |=> ctrl_r.gain == $past(gain_r);
  endproperty
  a_gain_gate: assert property (p_gain_gate) else $error("gain not applied");
  property p_pad;
    @(posedge clk_i) disable iff (!rst_n_r) !drst_r |=> out_a_o[3:1] == 3'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("pad bits nonzero");
  property p_fast_overrange_flag;
    @(posedge clk_i) disable iff (!rst_n_r)
      (lsb_en_r && lsb_src_r == 2'h3 && !drst_r) |=> out_b_o[0] == $past(fast_overrange_flag_b_i);
  endproperty
  a_fast_overrange_flag: assert property (p_fast_overrange_flag) else $error("fast over-range missing");
  property p_no_src;
    @(posedge clk_i) disable iff (!rst_n_r) !lsb_en_r |=> out_a_o[0] == 1'b0;
  endproperty
  a_no_src: assert property (p_no_src) else $error("source honoured while disabled");
  property p_keep_zone;
    @(posedge clk_i) disable iff (!rst_n_r) (drst_r && !wr_i) |=> $stable(zone_r) && $stable(nyq_en_r);
  endproperty
  a_keep_zone: assert property (p_keep_zone) else $error("reset disturbed zone");
  property p_rd_wo;
    @(posedge clk_i) disable iff (!rst_n_r) (rd_i && addr_i == amdc_pkg::DIG_RST_OFS) |=> rdata_o == 8'h00;
  endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("write-only bit readable");

  // ----------------------------------------
  // Control and word shaping checks
  // ----------------------------------------
  // Each check looks one cycle back, since every output is registered
  sequence s_rst_zero_wr;
    wr_i && addr_i == amdc_pkg::DIG_RST_OFS && !wdata_i[0];
  endsequence

  sequence s_fast_overrange_flag_on;
    lsb_en_r && lsb_src_r == amdc_pkg::LSB_SRC_FAST_OVERRANGE_FLAG && !drst_r;
  endsequence

  property p_rst_zero;
    @(posedge clk_i) disable iff (!rst_n_r)
      s_rst_zero_wr |=> !drst_r;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset pulse without a one");

  property p_rst_clear;
    @(posedge clk_i) disable iff (!rst_n_r)
      drst_r |=> out_a_o == 16'h0000 && out_b_o == 16'h0000;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("words not cleared by reset");

  property p_zone_pass;
    @(posedge clk_i) disable iff (!rst_n_r)
      nyq_en_r |=> ctrl_r.zone == $past(zone_r);
  endproperty
  a_zone_pass: assert property (p_zone_pass) else $error("zone not passed while enabled");

  property p_zone_flag;
    @(posedge clk_i) disable iff (!rst_n_r)
      1'b1 |=> ctrl_r.zone_en == $past(nyq_en_r);
  endproperty
  a_zone_flag: assert property (p_zone_flag) else $error("zone enable not mirrored");

  property p_zone_valid;
    @(posedge clk_i) disable iff (!rst_n_r)
      1'b1 |=> ctrl_r.zone_valid == ($past(zone_r) <= amdc_pkg::ZONE_THIRD);
  endproperty
  a_zone_valid: assert property (p_zone_valid) else $error("zone code validity wrong");

  property p_gain_unity;
    @(posedge clk_i) disable iff (!rst_n_r)
      !gain_en_r |=> ctrl_r.gain == 7'h20;
  endproperty
  a_gain_unity: assert property (p_gain_unity) else $error("gain not bypassed");

  property p_gain_flag;
    @(posedge clk_i) disable iff (!rst_n_r)
      1'b1 |=> ctrl_r.gain_en == $past(gain_en_r);
  endproperty
  a_gain_flag: assert property (p_gain_flag) else $error("gain enable not mirrored");

  property p_reorder;
    @(posedge clk_i) disable iff (!rst_n_r)
      1'b1 |=> ctrl_r.reorder_enable_first == $past(reord1_r) && ctrl_r.reorder_enable_second == $past(reord2_r);
  endproperty
  a_reorder: assert property (p_reorder) else $error("reorder bits not mirrored");

  property p_data_a;
    @(posedge clk_i) disable iff (!rst_n_r)
      !drst_r |=> out_a_o[15:4] == $past(adc_a_i);
  endproperty
  a_data_a: assert property (p_data_a) else $error("channel a result misplaced");

  property p_data_b;
    @(posedge clk_i) disable iff (!rst_n_r)
      !drst_r |=> out_b_o[15:4] == $past(adc_b_i) && out_b_o[3:1] == 3'h0;
  endproperty
  a_data_b: assert property (p_data_b) else $error("channel b result misplaced");

  property p_fast_overrange_flag_a;
    @(posedge clk_i) disable iff (!rst_n_r)
      s_fast_overrange_flag_on |=> out_a_o[0] == $past(fast_overrange_flag_a_i);
  endproperty
  a_fast_overrange_flag_a: assert property (p_fast_overrange_flag_a) else $error("fast over-range missing on a");

  property p_src_other;
    @(posedge clk_i) disable iff (!rst_n_r)
      (lsb_src_r != amdc_pkg::LSB_SRC_FAST_OVERRANGE_FLAG) |=> out_a_o[0] == 1'b0 && out_b_o[0] == 1'b0;
  endproperty
  a_src_other: assert property (p_src_other) else $error("lsb not zero for plain source");

  property p_no_src_b;
    @(posedge clk_i) disable iff (!rst_n_r)
      !lsb_en_r |=> out_b_o[0] == 1'b0;
  endproperty
  a_no_src_b: assert property (p_no_src_b) else $error("source honoured on b while disabled");

  property p_keep_bank;
    @(posedge clk_i) disable iff (!rst_n_r)
      (drst_r && !wr_i) |=> $stable(gain_r) && $stable(gain_en_r) && $stable(lsb_en_r);
  endproperty
  a_keep_bank: assert property (p_keep_bank) else $error("reset disturbed the bank");

  // Read data stands only in the cycle after the strobe
  property p_rd_idle;
    @(posedge clk_i) disable iff (!rst_n_r)
      !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ==== amdc_top_bench.sv ====
// Purpose: Self-checking bench for the main digital control bank
// Assumes: Outputs settle between a rising edge and the next falling edge
// Notes:   Driver queues expectations, a falling-edge monitor compares them
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module amdc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i, rst_n_i, wr_i, rd_i, fast_overrange_flag_a_i, fast_overrange_flag_b_i;
  logic                 digital_block_reset_o;
  logic                 rd_d = 1'b0;
  logic [7:0]           addr_i, wdata_i, rdata_o;
  logic [11:0]          adc_a_i, adc_b_i;
  logic [15:0]          out_a_o, out_b_o;
  amdc_pkg::amdc_ctrl_t ctrl_o;
  logic [31:0]          rnd = 32'hFA7C7851;
  int                   miscompares = 0;
  int                   checks_done = 0;
  logic [7:0]           rq[$];
  logic [19:0]          pq[$];
  logic [7:0]           ofs[9] = '{8'h42, 8'h44, 8'h4E, 8'h52, 8'h72, 8'hAB, 8'hAD, 8'hF7, 8'h10};
  logic [7:0]           msk[9] = '{8'h07, 8'h7F, 8'h80, 8'h81, 8'h08, 8'h01, 8'h03, 8'h00, 8'h00};
  string                nm[7] = '{"out_a", "out_b", "zone", "zone_valid", "gain", "reorder", "digital_block_reset"};

  amdc_top uut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .adc_a_i, .adc_b_i,
                .fast_overrange_flag_a_i, .fast_overrange_flag_b_i, .out_a_o, .out_b_o, .ctrl_o, .digital_block_reset_o);

  // ----------------------------------------
  // Clock, helpers, monitor
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] obs(input logic [3:0] k);
    case (k)
      0: return out_a_o;
      1: return out_b_o;
      2: return {12'h000, ctrl_o.zone_en, ctrl_o.zone};
      3: return {15'h0000, ctrl_o.zone_valid};
      4: return {8'h00, ctrl_o.gain_en, ctrl_o.gain};
      5: return {14'h0000, ctrl_o.reorder_enable_first, ctrl_o.reorder_enable_second};
      default: return {15'h0000, digital_block_reset_o};
    endcase
  endfunction

  // Bus requests start on a rising edge and hold for one cycle
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic read(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, addr_i, 8'h00);
  endtask

  task automatic probe(input logic [3:0] k, input logic [15:0] v);
    pq.push_back({k, v});
  endtask

  always @(posedge clk_i) rd_d <= rd_i;

  always @(negedge clk_i) begin
    logic [7:0]  r;
    logic [19:0] p;
    if (rd_d) begin
      r = rq.pop_front();
      `CHK("rdata", r, rdata_o)
    end
    while (pq.size() > 0) begin
      p = pq.pop_front();
      `CHK(nm[p[19:16]], p[15:0], obs(p[19:16]))
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Run takes under two hundred cycles
  initial begin
    #50000;
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int          k;
    logic [7:0]  g;
    logic [15:0] ea;
    {wr_i, rd_i, addr_i, wdata_i, adc_a_i, adc_b_i, fast_overrange_flag_a_i, fast_overrange_flag_b_i} = '0;
    rst_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(4);
    foreach (ofs[i]) read(ofs[i], 8'h00);
    foreach (ofs[i]) write(ofs[i], msk[i]);
    foreach (ofs[i]) read(ofs[i], msk[i]);
    foreach (ofs[i]) write(ofs[i], 8'h00);
    $display("register access test done");
    for (k = 0; k < 16; k++) begin
      write(8'h42, 8'(k & 7));
      write(8'h4E, {k[3], 7'h00});
      idle(2);
      probe(2, {12'h000, k[3], k[3] ? 3'(k) : 3'h0});
      if (k[3]) probe(3, {15'h0000, (k & 7) < 3});
    end
    $display("zone test done");
    for (k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      g = (k == 0) ? 8'h7F : {1'b0, rnd[6:0]};
      write(8'h44, g);
      write(8'h52, {k[0], 6'h00, k[1]});
      write(8'h72, {4'h0, k[0], 3'h0});
      idle(2);
      probe(4, {8'h00, k[1], k[1] ? g[6:0] : 7'h20});
      probe(5, {14'h0000, k[0], k[0]});
    end
    $display("gain and reorder test done");
    for (k = 0; k < 8; k++) begin
      write(8'hAB, {7'h00, k[2]});
      write(8'hAD, {6'h00, k[1:0]});
      rnd = lfsr(rnd);
      adc_a_i <= rnd[11:0];
      adc_b_i <= rnd[27:16];
      fast_overrange_flag_a_i <= rnd[12];
      fast_overrange_flag_b_i <= rnd[13];
      idle(2);
      ea = {rnd[11:0], 3'h0, k[2] && k[1:0] == 2'h3 && rnd[12]};
      probe(0, ea);
      probe(1, {rnd[27:16], 3'h0, k[2] && k[1:0] == 2'h3 && rnd[13]});
    end
    $display("word shaping test done");
    write(8'h42, 8'h02);
    write(8'h4E, 8'h80);
    write(8'hF7, 8'h01);
    probe(6, 16'h0001);
    idle(1);
    probe(6, 16'h0000);
    probe(0, 16'h0000);
    idle(2);
    probe(2, 16'h000A);
    probe(0, ea);
    read(8'hF7, 8'h00);
    read(8'h4E, 8'h80);
    idle(2);
    $display("digital reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
